// [common/clk_cond_pkg.sv]
/*
  Shared constants for the clock output channel configuration link:
  register indices, field positions, power-on defaults, path encodings,
  latency figures and the host's own bus register map.
  Assumes a single 250 MHz clock domain on both ends.
*/
package clk_cond_pkg;

  // ==========================================================
  // Register file shape
  localparam int REG_COUNT = 16;
  localparam int CH_COUNT = 8;
  localparam int IDX_W = 4;
  localparam logic [3:0] IDX_CH0 = 4'h0;
  localparam logic [3:0] IDX_LAST_CH = 4'h7;
  localparam logic [3:0] IDX_LEVEL = 4'h9;
  localparam logic [3:0] IDX_LOCK = 4'hb;
  localparam logic [3:0] IDX_LOOP = 4'hd;
  localparam logic [3:0] IDX_MISC = 4'he;
  localparam logic [3:0] IDX_FBDIV = 4'hf;

  // ==========================================================
  // Field positions
  localparam int SOFT_RST_BIT = 31;
  localparam int PATH_HI = 18;
  localparam int PATH_LO = 17;
  localparam int CH_EN_BIT = 16;
  localparam int DIV_HI = 15;
  localparam int DIV_LO = 8;
  localparam int DLY_HI = 7;
  localparam int DLY_LO = 4;
  localparam int BOOST_BIT = 16;
  localparam int PRESCALE_BIT = 15;
  localparam int OSC_FREQ_HI = 21;
  localparam int OSC_FREQ_LO = 14;
  localparam int FOUT_EN_BIT = 28;
  localparam int ALL_EN_BIT = 27;
  localparam int PWRDN_BIT = 26;
  localparam int LD_MODE_HI = 23;
  localparam int LD_MODE_LO = 20;
  localparam int REF_DIV_HI = 19;
  localparam int REF_DIV_LO = 8;
  localparam int POST_DIV_HI = 29;
  localparam int POST_DIV_LO = 26;
  localparam int FB_DIV_HI = 25;
  localparam int FB_DIV_LO = 8;
  localparam int PUMP_HI = 31;
  localparam int PUMP_LO = 30;

  // ==========================================================
  // Power-on defaults
  localparam logic [31:0] DEF_CHANNEL = 32'h0000_0100;
  localparam logic [31:0] DEF_LOOP = 32'h0002_8000;
  localparam logic [31:0] DEF_MISC = 32'h0800_0a00;
  localparam logic [31:0] DEF_FBDIV = 32'h0802_f800;
  localparam logic [31:0] DEF_ZERO = 32'h0000_0000;

  // ==========================================================
  // Path select encodings and latencies in ps
  localparam logic [1:0] PATH_BYPASS = 2'h0;
  localparam logic [1:0] PATH_DIVIDED = 2'h1;
  localparam logic [1:0] PATH_DELAYED = 2'h2;
  localparam logic [1:0] PATH_BOTH = 2'h3;
  localparam logic [11:0] LAT_BYPASS_PS = 12'h000;
  localparam logic [11:0] LAT_DIVIDED_PS = 12'h064;
  localparam logic [11:0] LAT_DELAYED_PS = 12'h190;
  localparam logic [11:0] LAT_BOTH_PS = 12'h1f4;
  localparam logic [11:0] DLY_STEP_PS = 12'h096;
  localparam logic [8:0] RATIO_ONE = 9'h001;
  localparam logic [1:0] LD_PRESCALE_LAST = 2'h3;

  // ==========================================================
  // Host bus registers
  localparam logic [7:0] ADDR_CMD_DATA = 8'h00;
  localparam logic [7:0] ADDR_CMD_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h0c;
  localparam int CTRL_ALLOW_RST_BIT = 8;
  localparam int PIN_GOE_DRIVE_BIT = 0;
  localparam int PIN_GOE_LEVEL_BIT = 1;
  localparam int PIN_ALIGN_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REF_BUSY_BIT = 1;
  localparam int ST_REF_CODE_BIT = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ALIGN_TIME_NS = 20;
  localparam int ALIGN_CYCLES = (ALIGN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power-on value of each register
  function automatic logic [31:0] default_word(input logic [3:0] idx);
    logic [31:0] w;
    w = DEF_ZERO;
    if (idx <= IDX_LAST_CH) begin
      w = DEF_CHANNEL;
    end else if (idx == IDX_LOOP) begin
      w = DEF_LOOP;
    end else if (idx == IDX_MISC) begin
      w = DEF_MISC;
    end else if (idx == IDX_FBDIV) begin
      w = DEF_FBDIV;
    end
    return w;
  endfunction : default_word

endpackage : clk_cond_pkg

// [common/clk_cond_link_if.sv]
/*
  Link between the host controller and the clock conditioner:
  a one-cycle register write strobe, the output enable pin and the
  divider alignment pin.
  Assumes both ends run on the same clock; the enable pin floats high.
*/
`timescale 1ns/100ps
interface clk_cond_link_if;
  logic wr_stb;
  logic [3:0] wr_index;
  logic [31:0] wr_data;
  logic goe_out;
  logic goe_oe_n;
  logic global_output_enable_pin;
  logic div_align_n;

  // ==========================================================
  // Pin level: undriven reads high
  assign global_output_enable_pin = goe_oe_n ? 1'b1 : goe_out;

  modport device (
    input wr_stb,
    input wr_index,
    input wr_data,
    input global_output_enable_pin,
    input div_align_n
  );

  modport host (
    output wr_stb,
    output wr_index,
    output wr_data,
    output goe_out,
    output goe_oe_n,
    output div_align_n
  );
endinterface : clk_cond_link_if

// [src/clk_cond_device.sv]
/*
  Clock conditioner configuration end: register file written over the
  link, per-channel path, divide, delay and enable decoding, lock
  detect prescaler.
  Assumes the host writes whole registers with one-cycle strobes.
*/
// How it works
// - Soft reset bit restores all defaults
// - Soft reset write ignores other fields
// - Host writes soft reset zero unless used
// - Two-bit path select at 18:17
// - Path latency 100, 400, 500 ps
// - Divider applies only in divided modes
// - Ratio is twice the divide code
// - Total division is post-divider times ratio
// - Host pulses alignment pin after dividers
// - Delay applies only in delayed modes
// - Delay is code times 150 ps
// - Output needs own, global bit, pin
// - Global enable bit 27 of register 14
// - Channels start disabled, divide code one
// - Swing boost bit defaults to zero
// - Lock prescale bit defaults to zero
// - Registers 0 to 7 drive outputs 0-7
// - Prescale divides lock detect by four
`timescale 1ns/100ps
module clk_cond_device
  import clk_cond_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  clk_cond_link_if.device link,
  input wire logic ld_ref_tick,
  output logic [7:0] clock_output_channel_on,
  output logic [7:0][1:0] output_path_select,
  output logic [7:0][8:0] channel_ratio,
  output logic [7:0][12:0] channel_total_div,
  output logic [7:0][11:0] channel_delay_ps,
  output logic [7:0][11:0] channel_latency_ps,
  output logic output_swing_boost,
  output logic lock_detect_prescale,
  output logic ld_tick_out,
  output logic [3:0] oscillator_post_divide,
  output logic [7:0] osc_freq_mhz,
  output logic [11:0] ref_divide,
  output logic [17:0] fb_divide,
  output logic [3:0] ld_pin_mode,
  output logic [1:0] pump_gain,
  output logic fout_enable,
  output logic power_down,
  output logic align_active
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0][31:0] regs;
    logic [7:0] on;
    logic [7:0][1:0] path;
    logic [7:0][8:0] ratio;
    logic [7:0][12:0] total;
    logic [7:0][11:0] dly;
    logic [7:0][11:0] lat;
    logic boost;
    logic prescale;
    logic [1:0] ld_cnt;
    logic ld_tick;
    logic [3:0] post_div;
    logic [7:0] osc_freq;
    logic [11:0] ref_div;
    logic [17:0] fb_div;
    logic [3:0] ld_mode;
    logic [1:0] pump;
    logic fout;
    logic pwrdn;
    logic align;
  } dev_state_type;

  dev_state_type st_r;
  dev_state_type st_nxt;

  function automatic dev_state_type reset_state();
    dev_state_type s;
    s = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      s.regs[i] = default_word(4'(i));
    end
    for (int i = 0; i < CH_COUNT; i++) begin
      s.ratio[i] = RATIO_ONE;
    end
    return s;
  endfunction : reset_state

  // ==========================================================
  // Next state
  always_comb begin
    logic [1:0] p;
    logic [7:0] dcode;
    logic [3:0] ycode;
    logic all_en;
    p = PATH_BYPASS;
    dcode = 8'h00;
    ycode = 4'h0;
    all_en = 1'b0;
    st_nxt = st_r;

    // Register writes
    if (link.wr_stb) begin
      if (link.wr_index == IDX_CH0 && link.wr_data[SOFT_RST_BIT]) begin
        for (int i = 0; i < REG_COUNT; i++) begin
          st_nxt.regs[i] = default_word(4'(i));
        end
      end else begin
        st_nxt.regs[link.wr_index] = link.wr_data;
      end
    end

    // Global fields
    st_nxt.boost = st_r.regs[IDX_LEVEL][BOOST_BIT];
    st_nxt.prescale = st_r.regs[IDX_LOCK][PRESCALE_BIT];
    st_nxt.post_div = st_r.regs[IDX_FBDIV][POST_DIV_HI:POST_DIV_LO];
    st_nxt.osc_freq = st_r.regs[IDX_LOOP][OSC_FREQ_HI:OSC_FREQ_LO];
    st_nxt.ref_div = st_r.regs[IDX_MISC][REF_DIV_HI:REF_DIV_LO];
    st_nxt.fb_div = st_r.regs[IDX_FBDIV][FB_DIV_HI:FB_DIV_LO];
    st_nxt.ld_mode = st_r.regs[IDX_MISC][LD_MODE_HI:LD_MODE_LO];
    st_nxt.pump = st_r.regs[IDX_FBDIV][PUMP_HI:PUMP_LO];
    st_nxt.fout = st_r.regs[IDX_MISC][FOUT_EN_BIT];
    st_nxt.pwrdn = st_r.regs[IDX_MISC][PWRDN_BIT];
    st_nxt.align = ~link.div_align_n;
    all_en = st_r.regs[IDX_MISC][ALL_EN_BIT] & ~st_r.regs[IDX_MISC][PWRDN_BIT];

    // Per-channel decoding, register n drives output n
    for (int i = 0; i < CH_COUNT; i++) begin
      p = st_r.regs[i][PATH_HI:PATH_LO];
      dcode = st_r.regs[i][DIV_HI:DIV_LO];
      ycode = st_r.regs[i][DLY_HI:DLY_LO];
      st_nxt.path[i] = p;
      st_nxt.on[i] = st_r.regs[i][CH_EN_BIT] & all_en
        & link.global_output_enable_pin;
      if (p[0]) begin
        st_nxt.ratio[i] = {dcode, 1'b0};
      end else begin
        st_nxt.ratio[i] = RATIO_ONE;
      end
      st_nxt.total[i] = 13'(st_r.post_div) * 13'(st_r.ratio[i]);
      if (p[1]) begin
        st_nxt.dly[i] = 12'(ycode) * DLY_STEP_PS;
      end else begin
        st_nxt.dly[i] = 12'h000;
      end
      case (st_r.path[i])
        PATH_BYPASS: st_nxt.lat[i] = LAT_BYPASS_PS;
        PATH_DIVIDED: st_nxt.lat[i] = LAT_DIVIDED_PS;
        PATH_DELAYED: st_nxt.lat[i] = LAT_DELAYED_PS + st_r.dly[i];
        PATH_BOTH: st_nxt.lat[i] = LAT_BOTH_PS + st_r.dly[i];
        default: st_nxt.lat[i] = LAT_BYPASS_PS;
      endcase
    end

    // Lock detect prescaler
    st_nxt.ld_tick = 1'b0;
    if (ld_ref_tick) begin
      if (st_r.prescale) begin
        st_nxt.ld_cnt = st_r.ld_cnt + 2'h1;
        st_nxt.ld_tick = (st_r.ld_cnt == LD_PRESCALE_LAST);
      end else begin
        st_nxt.ld_cnt = 2'h0;
        st_nxt.ld_tick = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= reset_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign clock_output_channel_on = st_r.on;
  assign output_path_select = st_r.path;
  assign channel_ratio = st_r.ratio;
  assign channel_total_div = st_r.total;
  assign channel_delay_ps = st_r.dly;
  assign channel_latency_ps = st_r.lat;
  assign output_swing_boost = st_r.boost;
  assign lock_detect_prescale = st_r.prescale;
  assign ld_tick_out = st_r.ld_tick;
  assign oscillator_post_divide = st_r.post_div;
  assign osc_freq_mhz = st_r.osc_freq;
  assign ref_divide = st_r.ref_div;
  assign fb_divide = st_r.fb_div;
  assign ld_pin_mode = st_r.ld_mode;
  assign pump_gain = st_r.pump;
  assign fout_enable = st_r.fout;
  assign power_down = st_r.pwrdn;
  assign align_active = st_r.align;

endmodule : clk_cond_device

// [src/clk_cond_host.sv]
/*
  Host controller end: an AHB-Lite slave with command, status and pin
  registers, and a sequencer that writes the conditioner's registers,
  follows a soft reset with a rewrite and pulses the alignment pin.
  Assumes a single AHB-Lite master and the same clock as the device.
*/
`timescale 1ns/100ps
module clk_cond_host
  import clk_cond_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  clk_cond_link_if.host link
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_RESEND = 3'b010,
    HS_ALIGN = 3'b100
  } host_fsm_type;

  typedef struct packed {
    host_fsm_type fsm;
    logic [31:0] cmd_data;
    logic [3:0] last_idx;
    logic ref_busy;
    logic ref_code;
    logic goe_drive;
    logic goe_level;
    logic [3:0] align_cnt;
    logic wr_pend;
    logic [7:0] pend_addr;
    logic [31:0] rdata;
    logic wr_stb;
    logic [3:0] wr_index;
    logic [31:0] wr_data;
    logic align_n;
  } host_state_type;

  host_state_type st_r;
  host_state_type st_nxt;

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] word;
    logic [3:0] idx;
    word = 32'h0000_0000;
    idx = 4'h0;
    st_nxt = st_r;
    st_nxt.wr_stb = 1'b0;
    st_nxt.wr_pend = 1'b0;

    // Sequencer
    case (st_r.fsm)
      HS_IDLE: st_nxt.fsm = HS_IDLE;
      HS_RESEND: begin
        st_nxt.wr_stb = 1'b1;
        st_nxt.wr_data[SOFT_RST_BIT] = 1'b0;
        st_nxt.fsm = HS_IDLE;
      end
      HS_ALIGN: begin
        if (st_r.align_cnt == 4'h1) begin
          st_nxt.align_n = 1'b1;
          st_nxt.fsm = HS_IDLE;
        end
        st_nxt.align_cnt = st_r.align_cnt - 4'h1;
      end
      default: st_nxt.fsm = HS_IDLE;
    endcase

    // Bus write data phase
    if (st_r.wr_pend) begin
      case (st_r.pend_addr)
        ADDR_CMD_DATA: st_nxt.cmd_data = hwdata;
        ADDR_CMD_CTRL: begin
          idx = hwdata[3:0];
          word = st_r.cmd_data;
          if (st_r.fsm != HS_IDLE) begin
            st_nxt.ref_busy = 1'b1;
          end else if (idx <= IDX_LAST_CH && word[DIV_HI:DIV_LO] == 8'h00) begin
            st_nxt.ref_code = 1'b1;
          end else begin
            if (idx != IDX_CH0 || !hwdata[CTRL_ALLOW_RST_BIT]) begin
              word[SOFT_RST_BIT] = 1'b0;
            end
            st_nxt.wr_stb = 1'b1;
            st_nxt.wr_index = idx;
            st_nxt.wr_data = word;
            st_nxt.last_idx = idx;
            if (idx == IDX_CH0 && word[SOFT_RST_BIT]) begin
              st_nxt.fsm = HS_RESEND;
            end
          end
        end
        ADDR_STATUS: begin
          if (hwdata[ST_REF_BUSY_BIT]) begin
            st_nxt.ref_busy = 1'b0;
          end
          if (hwdata[ST_REF_CODE_BIT]) begin
            st_nxt.ref_code = 1'b0;
          end
        end
        ADDR_PIN_CTRL: begin
          st_nxt.goe_drive = hwdata[PIN_GOE_DRIVE_BIT];
          st_nxt.goe_level = hwdata[PIN_GOE_LEVEL_BIT];
          if (hwdata[PIN_ALIGN_BIT]) begin
            if (st_r.fsm != HS_IDLE) begin
              st_nxt.ref_busy = 1'b1;
            end else begin
              st_nxt.align_n = 1'b0;
              st_nxt.align_cnt = 4'(ALIGN_CYCLES);
              st_nxt.fsm = HS_ALIGN;
            end
          end
        end
        default: st_nxt.cmd_data = st_r.cmd_data;
      endcase
    end

    // Bus address phase
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.pend_addr = haddr[7:0];
      case (haddr[7:0])
        ADDR_CMD_DATA: st_nxt.rdata = st_nxt.cmd_data;
        ADDR_STATUS: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[ST_BUSY_BIT] = (st_nxt.fsm != HS_IDLE);
          st_nxt.rdata[ST_REF_BUSY_BIT] = st_nxt.ref_busy;
          st_nxt.rdata[ST_REF_CODE_BIT] = st_nxt.ref_code;
          st_nxt.rdata[7:4] = st_nxt.last_idx;
        end
        ADDR_PIN_CTRL: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[PIN_GOE_DRIVE_BIT] = st_nxt.goe_drive;
          st_nxt.rdata[PIN_GOE_LEVEL_BIT] = st_nxt.goe_level;
          st_nxt.rdata[PIN_ALIGN_BIT] = ~st_nxt.align_n;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.fsm <= HS_IDLE;
      st_r.align_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign link.wr_stb = st_r.wr_stb;
  assign link.wr_index = st_r.wr_index;
  assign link.wr_data = st_r.wr_data;
  assign link.goe_out = st_r.goe_level;
  assign link.goe_oe_n = ~st_r.goe_drive;
  assign link.div_align_n = st_r.align_n;

endmodule : clk_cond_host

// [sim/clk_cond_link_properties.sv]
/*
  Concurrent checks on the host-to-device link and on the channel enables.
  Assumes one clock and one synchronous active-high reset for both ends.
*/
`timescale 1ns/100ps
module clk_cond_link_properties
  import clk_cond_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_stb,
  input wire logic [3:0] wr_index,
  input wire logic [31:0] wr_data,
  input wire logic goe_oe_n,
  input wire logic global_output_enable_pin,
  input wire logic div_align_n,
  input wire logic [7:0] clock_output_channel_on
);
  // ==========================================================
  // Link and enable properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_rst_link_idle: assert property ($fell(sys_rst) |->
    !wr_stb && goe_oe_n && div_align_n) else $error("link busy after reset");
  a_rst_chan_off: assert property ($fell(sys_rst) |->
    clock_output_channel_on == 8'h00) else $error("channel on after reset");
  a_soft_rst_rewrite: assert property (wr_stb && wr_index == IDX_CH0 && wr_data[31]
    |=> wr_stb && wr_index == IDX_CH0 && !wr_data[31]) else $error("no rewrite of reg0");
  a_soft_rst_off: assert property (wr_stb && wr_index == IDX_CH0 && wr_data[31]
    |-> ##2 clock_output_channel_on == 8'h00) else $error("outputs kept over reset");
  a_div_code_nonzero: assert property (wr_stb && wr_index <= IDX_LAST_CH
    |-> wr_data[15:8] != 8'h00) else $error("divide code zero sent");
  a_align_width: assert property ($fell(div_align_n) |=>
    (!div_align_n) [*4] ##1 div_align_n) else $error("align pulse width wrong");
  a_pin_low_off: assert property (!global_output_enable_pin |=>
    clock_output_channel_on == 8'h00) else $error("output on with pin low");
  a_on_rise_cause: assert property ($rose(|clock_output_channel_on) |->
    $past(wr_stb, 2) || ($past(global_output_enable_pin, 1) != $past(global_output_enable_pin, 2)))
    else $error("output on without cause");

  c_soft_rst: cover property (wr_stb && wr_index == IDX_CH0 && wr_data[31]);
  c_align: cover property ($fell(div_align_n));
  c_pin_low: cover property (!global_output_enable_pin);
endmodule : clk_cond_link_properties

// [sim/clock_output_channel_config_tb.sv]
/*
  Bench for host and device joined by the link: AHB-Lite master tasks,
  channel decode checks, pin, soft reset, lock prescale and align tests.
  Assumes the host answers with zero wait states and OKAY.
*/
`timescale 1ns/100ps
module clock_output_channel_config_tb
  import clk_cond_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ld_ref_tick = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, boost, pre, ld_out, align;
  logic [7:0] on;
  logic [7:0][1:0] psel;
  logic [7:0][8:0] ratio;
  logic [7:0][12:0] tdiv;
  logic [7:0][11:0] dly, lat;
  logic [3:0] pdiv, ldm;
  logic [7:0] oscf;
  logic [11:0] rdiv;
  logic [17:0] fbd;
  logic [1:0] pump;
  logic fout, pwrdn;
  int miscompares = 0, n_compared = 0, n_ticks = 0, s;

  clk_cond_link_if link ();
  clk_cond_host i_clk_cond_host (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  clk_cond_device i_clk_cond_device (.clk(clk), .sys_rst(sys_rst), .link(link),
    .ld_ref_tick(ld_ref_tick), .clock_output_channel_on(on), .output_path_select(psel),
    .channel_ratio(ratio), .channel_total_div(tdiv), .channel_delay_ps(dly),
    .channel_latency_ps(lat), .output_swing_boost(boost), .lock_detect_prescale(pre),
    .ld_tick_out(ld_out), .oscillator_post_divide(pdiv), .osc_freq_mhz(oscf),
    .ref_divide(rdiv), .fb_divide(fbd), .ld_pin_mode(ldm), .pump_gain(pump),
    .fout_enable(fout), .power_down(pwrdn), .align_active(align));
  clk_cond_link_properties i_clk_cond_link_properties (.clk(clk), .sys_rst(sys_rst),
    .wr_stb(link.wr_stb), .wr_index(link.wr_index), .wr_data(link.wr_data),
    .goe_oe_n(link.goe_oe_n), .global_output_enable_pin(link.global_output_enable_pin),
    .div_align_n(link.div_align_n), .clock_output_channel_on(on));

  // ==========================================================
  // Clock, tick counter, helpers
  always #2 clk = ~clk;
  always @(posedge clk) if (ld_out === 1'b1) n_ticks <= n_ticks + 1;

  function automatic logic [7:0] dvf(input int n);
    return (n == 7) ? 8'hff : 8'(n + 1);
  endfunction : dvf
  function automatic logic [3:0] dlf(input int n);
    return (n == 7) ? 4'hf : 4'(n);
  endfunction : dlf
  function automatic logic [31:0] wv(input logic [1:0] p, input logic e,
    input logic [7:0] dv, input logic [3:0] dl);
    return {13'h0, p, e, dv, dl, 4'h0};
  endfunction : wv

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task dw(input logic [3:0] i, input logic [31:0] w, input logic al);
    ahb(1'b1, ADDR_CMD_DATA, w);
    ahb(1'b1, ADDR_CMD_CTRL, {23'h0, al, 4'h0, i});
    repeat (8) @(posedge clk);
  endtask : dw

  task chan(input int n, input logic [1:0] p, input logic e, input logic [7:0] dv,
    input logic [3:0] dl);
    logic [8:0] r;
    logic [11:0] d, l;
    r = p[0] ? {dv, 1'b0} : RATIO_ONE;
    d = p[1] ? 12'(dl) * DLY_STEP_PS : 12'h000;
    l = (p == PATH_BYPASS) ? LAT_BYPASS_PS : (p == PATH_DIVIDED) ? LAT_DIVIDED_PS :
      (p == PATH_DELAYED) ? LAT_DELAYED_PS + d : LAT_BOTH_PS + d;
    chk("path", 32'(p), 32'(psel[n]));
    chk("on", 32'(e), 32'(on[n]));
    chk("ratio", 32'(r), 32'(ratio[n]));
    chk("delay", 32'(d), 32'(dly[n]));
    chk("latency", 32'(l), 32'(lat[n]));
    chk("total", 32'(r) * 32'(DEF_FBDIV[POST_DIV_HI:POST_DIV_LO]), 32'(tdiv[n]));
  endtask : chan

  task glob;
    chk("post div", 32'(DEF_FBDIV[POST_DIV_HI:POST_DIV_LO]), 32'(pdiv));
    chk("osc freq", 32'(DEF_LOOP[OSC_FREQ_HI:OSC_FREQ_LO]), 32'(oscf));
    chk("ref div", 32'(DEF_MISC[REF_DIV_HI:REF_DIV_LO]), 32'(rdiv));
    chk("fb div", 32'(DEF_FBDIV[FB_DIV_HI:FB_DIV_LO]), 32'(fbd));
    chk("ld mode", 32'(DEF_MISC[LD_MODE_HI:LD_MODE_LO]), 32'(ldm));
    chk("pump", 32'(DEF_FBDIV[PUMP_HI:PUMP_LO]), 32'(pump));
    chk("fout", 32'(DEF_MISC[FOUT_EN_BIT]), 32'(fout));
    chk("power down", 32'(DEF_MISC[PWRDN_BIT]), 32'(pwrdn));
  endtask : glob

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    miscompares++;
    $display("BAD watchdog expected done seen hang");
    complete_run;
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int n = 0; n < 8; n++) chan(n, PATH_BYPASS, 1'b0, 8'h01, 4'h0);
    chk("boost", 32'h0, 32'(boost));
    chk("prescale", 32'h0, 32'(pre));
    glob;
    $display("test defaults done");
    for (int n = 0; n < 8; n++) dw(4'(n), wv(2'(n), 1'b1, dvf(n), dlf(n)), 1'b0);
    for (int n = 0; n < 8; n++) chan(n, 2'(n), 1'b1, dvf(n), dlf(n));
    $display("test channels done");
    for (int k = 0; k < 3; k++) begin
      ahb(1'b1, ADDR_PIN_CTRL, (k == 0) ? 32'h1 : (k == 1) ? 32'h3 : 32'h0);
      repeat (3) @(posedge clk);
      chk("pin on", (k == 0) ? 32'h0 : 32'hff, 32'(on));
    end
    dw(IDX_MISC, DEF_MISC & ~32'h0800_0000, 1'b0);
    chk("all off", 32'h0, 32'(on));
    dw(IDX_MISC, DEF_MISC | 32'h0400_0000, 1'b0);
    chk("pwrdn off", 32'h0, 32'(on));
    chk("pwrdn", 32'h1, 32'(pwrdn));
    dw(IDX_MISC, DEF_MISC, 1'b0);
    chk("all on", 32'hff, 32'(on));
    $display("test enables done");
    dw(4'h3, wv(PATH_BYPASS, 1'b0, 8'h00, 4'h0), 1'b0);
    chan(3, 2'h3, 1'b1, dvf(3), dlf(3));
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk("code flag", 32'h1, 32'(rd[ST_REF_CODE_BIT]));
    chk("last index", 32'(IDX_MISC), 32'(rd[7:4]));
    ahb(1'b1, ADDR_STATUS, 32'h4);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk("code flag clr", 32'h0, 32'(rd[ST_REF_CODE_BIT]));
    $display("test refusal done");
    dw(IDX_LEVEL, 32'h0001_0000, 1'b0);
    chk("boost", 32'h1, 32'(boost));
    for (int k = 1; k >= 0; k--) begin
      dw(IDX_LOCK, k ? 32'h0000_8000 : 32'h0, 1'b0);
      chk("prescale", 32'(k), 32'(pre));
      s = n_ticks;
      repeat (8) begin
        ld_ref_tick <= 1'b1;
        @(posedge clk);
        ld_ref_tick <= 1'b0;
        repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      chk("ticks", k ? 32'h2 : 32'h8, 32'(n_ticks - s));
    end
    $display("test lock prescale done");
    dw(IDX_LOOP, 32'h0000_4000, 1'b0);
    chk("osc freq", 32'h1, 32'(oscf));
    dw(IDX_CH0, 32'h8000_0000 | wv(PATH_DIVIDED, 1'b1, 8'h03, 4'h0), 1'b0);
    chan(0, PATH_DIVIDED, 1'b1, 8'h03, 4'h0);
    chan(1, 2'h1, 1'b1, dvf(1), dlf(1));
    dw(IDX_CH0, 32'h8000_0000 | wv(PATH_BOTH, 1'b1, 8'h02, 4'h5), 1'b1);
    chan(0, PATH_BOTH, 1'b1, 8'h02, 4'h5);
    for (int n = 1; n < 8; n++) chan(n, PATH_BYPASS, 1'b0, 8'h01, 4'h0);
    chk("boost", 32'h0, 32'(boost));
    glob;
    $display("test soft reset done");
    ahb(1'b1, ADDR_PIN_CTRL, 32'h4);
    s = 0;
    repeat (20) begin
      @(posedge clk);
      if (align === 1'b1) s++;
    end
    chk("align", 32'(ALIGN_CYCLES), 32'(s));
    ahb(1'b1, ADDR_PIN_CTRL, 32'h4);
    ahb(1'b1, ADDR_CMD_CTRL, 32'h1);
    ahb(1'b0, ADDR_STATUS, 32'h0);
    chk("busy refusal", 32'h3, 32'(rd[2:0]));
    $display("test align done");
    complete_run;
  end
endmodule : clock_output_channel_config_tb
